// File: design/canlp_pkg.sv
/*
  canlp_pkg: constants and types for the can low-power mode controller.
  assumes: used only as canlp_pkg::name, never imported.
*/
`default_nettype none
package canlp_pkg;
	// ------------------------------------------------------------
	// register map (byte addresses, one 32-bit word each)
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00; // control bits
	localparam logic [7:0] OFS_STATUS = 8'h04; // mode and sync state, read only
	localparam logic [7:0] OFS_FLAG = 8'h08; // wakeup flag, write one to clear

	// control field positions
	localparam int CTRL_SLEEP_RQ = 0;
	localparam int CTRL_SOFT_RST = 1;
	localparam int CTRL_WAKE_IE = 2;
	localparam int CTRL_FILT_SEL = 3;
	localparam int CTRL_LINK_EN = 4;
	// status field positions
	localparam int STAT_SLEEP_ACK = 0;
	localparam int STAT_MODE_LSB = 1; // four bits of one-hot mode
	localparam int STAT_SYNCED = 5;
	localparam int FLAG_WAKE = 0;

	// reset values
	localparam logic SLEEP_RQ_RST = 1'b0;
	localparam logic SOFT_RST_RST = 1'b1; // comes up stopped for configuration
	localparam logic WAKE_IE_RST = 1'b0;
	localparam logic FILT_SEL_RST = 1'b0;
	localparam logic LINK_EN_RST = 1'b0;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int RESYNC_BITS = 11; // recessive bits before joining the bus
	localparam int FILT_CYCLES = 16; // least low time accepted as wakeup

	// one-hot controller modes
	typedef enum logic [3:0] {
		MODE_NORMAL = 4'h1,
		MODE_SLEEP = 4'h2,
		MODE_SOFTRST = 4'h4,
		MODE_PWRDN = 4'h8
	} canlp_mode_e;

	// software control bits travel together
	typedef struct packed {
		logic link_en;
		logic filt_sel;
		logic wake_ie;
		logic soft_rst;
		logic sleep_rq;
	} canlp_ctrl_s;
endpackage
`default_nettype wire

// File: design/canlp_top.sv
/*
  canlp_top: power-state, wakeup, resync and timer-link control around a can core.
  assumes: protocol core supplies busy levels, a bit-time tick and a valid-frame
  pulse on the same clock; can_rx comes straight from a pin; axi4-lite master.
*/
// The AXI4-Lite slave port and the address map were decided locally.
// Function
// - mode from cpu stop, ack and soft reset
// - gate core clocks; power-down gates all
// - wakeup interrupt needs ack and enable; code also sets it from activity in power-down, with no ack
// - sleep deferred until transmit and receive idle
// - acknowledge held high throughout sleep
// - bus-off recovery count paused while asleep
// - transmit recessive in sleep and power-down
// - sleep allows buffer access, no copy/abort
// - wake on activity, request clear, soft reset
// - request clear ignored until acknowledged
// - wait eleven recessive bits after wakeup
// - pending actions and bus-off count resume
// - soft reset halts traffic, registers stay
// - power-down aborts traffic, blocks register access
// - activity wakes cpu; ignore until synced
// - cpu wait keeps core active, irq exits
// - optional glitch filter on receive in sleep
// - one-bit timer pulse after valid frame
// - link enable routes pulse to capture channel
// - flag cleared by one, if condition gone
`timescale 1ns/10ps
`default_nettype none
module canlp_top (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// axi4-lite write
	input wire logic [canlp_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [canlp_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// cpu state
	input wire logic cpu_stop,
	input wire logic cpu_wait,
	output logic cpu_stop_wake,
	output logic cpu_wait_exit,
	// protocol core
	input wire logic core_tx_pending,
	input wire logic core_rx_busy,
	input wire logic core_bus_off,
	input wire logic core_bit_tick,
	input wire logic core_frame_ok,
	input wire logic core_irq,
	input wire logic core_tx_bit,
	output logic core_rx_bit,
	output logic core_clk_en,
	output logic reg_clk_en,
	output logic core_halt,
	output logic core_pending_en,
	output logic busoff_count_en,
	// pins and links
	input wire logic can_rx,
	output logic can_tx,
	output logic wakeup_irq,
	output logic capture_ch0
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	canlp_pkg::canlp_mode_e mode_reg, mode_next; // controller mode
	canlp_pkg::canlp_ctrl_s ctrl_reg, ctrl_next; // software control bits
	logic wake_flag_reg, wake_flag_next; // sticky wakeup flag
	logic synced_reg, synced_next; // eleven recessive bits seen
	logic [3:0] resync_cnt_reg, resync_cnt_next; // recessive bit count
	logic [7:0] filt_cnt_reg, filt_cnt_next; // low time in cycles
	logic rx_s1_reg, rx_s2_reg, rx_s3_reg; // pin synchroniser
	logic rx_level_reg, rx_level_next; // settled receive level
	logic pulse_arm_reg, pulse_arm_next; // frame seen, wait for bit edge
	logic pulse_reg, pulse_next; // one bit time pulse
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [1:0] rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic activity; // wakeup-qualified bus activity
	logic wr_go, rd_go; // bus transfers taken this cycle
	logic asleep; // sleep or power-down

	localparam logic [3:0] RESYNC_LAST = 4'(canlp_pkg::RESYNC_BITS - 1);
	localparam logic [7:0] FILT_LAST = 8'(canlp_pkg::FILT_CYCLES - 1);

	// ------------------------------------------------------------
	// receive pin synchroniser: change counts when stages 2 and 3 agree
	// ------------------------------------------------------------
	always_comb
	begin
		rx_level_next = rx_level_reg;
		if (rx_s2_reg == rx_s3_reg)
			rx_level_next = rx_s3_reg;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			rx_s1_reg <= 1'b1; // recessive idle
			rx_s2_reg <= 1'b1;
			rx_s3_reg <= 1'b1;
			rx_level_reg <= 1'b1;
		end
		else
		begin
			rx_s1_reg <= can_rx;
			rx_s2_reg <= rx_s1_reg;
			rx_s3_reg <= rx_s2_reg;
			rx_level_reg <= rx_level_next;
		end
	end

	// ------------------------------------------------------------
	// wakeup detect, with optional low-pass filter
	// ------------------------------------------------------------
	assign asleep = (mode_reg == canlp_pkg::MODE_SLEEP) || (mode_reg == canlp_pkg::MODE_PWRDN);

	// filter needs the line low a fixed number of cycles; a glitch restarts it
	always_comb
	begin
		filt_cnt_next = 8'h00;
		if (asleep && !rx_level_reg && filt_cnt_reg != FILT_LAST)
			filt_cnt_next = filt_cnt_reg + 8'h01;
		else if (asleep && !rx_level_reg)
			filt_cnt_next = filt_cnt_reg;
	end

	// unfiltered wake reacts to the first settled dominant level
	assign activity = asleep && !rx_level_reg &&
		(!ctrl_reg.filt_sel || filt_cnt_reg == FILT_LAST);

	// ------------------------------------------------------------
	// mode machine and software control bits
	// ------------------------------------------------------------
	assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
	assign rd_go = s_axi_arvalid && !rvalid_reg;

	always_comb
	begin
		canlp_pkg::canlp_ctrl_s wr_ctrl;
		wr_ctrl = ctrl_reg;
		ctrl_next = ctrl_reg;
		mode_next = mode_reg;
		wake_flag_next = wake_flag_reg;
		// control write; power-down blocks every register access
		if (wr_go && mode_reg != canlp_pkg::MODE_PWRDN &&
			s_axi_awaddr == canlp_pkg::OFS_CTRL && s_axi_wstrb[0])
		begin
			wr_ctrl = s_axi_wdata[4:0];
			ctrl_next = wr_ctrl;
			// withdrawing the request only counts once acknowledged
			if (!wr_ctrl.sleep_rq && mode_reg != canlp_pkg::MODE_SLEEP)
				ctrl_next.sleep_rq = ctrl_reg.sleep_rq;
		end
		// mode selection; cpu stop overrides everything
		unique case (mode_reg)
			canlp_pkg::MODE_NORMAL:
			begin
				if (ctrl_next.soft_rst)
					mode_next = canlp_pkg::MODE_SOFTRST;
				else if (ctrl_reg.sleep_rq && !core_tx_pending && !core_rx_busy)
					mode_next = canlp_pkg::MODE_SLEEP;
			end
			canlp_pkg::MODE_SLEEP:
			begin
				if (ctrl_next.soft_rst)
					mode_next = canlp_pkg::MODE_SOFTRST;
				else if (!ctrl_next.sleep_rq)
					mode_next = canlp_pkg::MODE_NORMAL;
				else if (activity)
				begin
					mode_next = canlp_pkg::MODE_NORMAL;
					ctrl_next.sleep_rq = 1'b0; // bus wake ends the request too
				end
			end
			canlp_pkg::MODE_SOFTRST:
			begin
				if (!ctrl_next.soft_rst)
					mode_next = canlp_pkg::MODE_NORMAL;
			end
			canlp_pkg::MODE_PWRDN:
			begin
				mode_next = ctrl_reg.soft_rst ? canlp_pkg::MODE_SOFTRST : canlp_pkg::MODE_NORMAL;
			end
			default:
			begin
				mode_next = canlp_pkg::MODE_SOFTRST; // illegal code recovers stopped
			end
		endcase
		if (cpu_stop)
			mode_next = canlp_pkg::MODE_PWRDN;
		// wakeup flag: set wins over a clear in the same cycle
		if (wr_go && mode_reg != canlp_pkg::MODE_PWRDN &&
			s_axi_awaddr == canlp_pkg::OFS_FLAG && s_axi_wstrb[0] &&
			s_axi_wdata[canlp_pkg::FLAG_WAKE] && !activity)
			wake_flag_next = 1'b0;
		if (activity && ctrl_reg.wake_ie)
			wake_flag_next = 1'b1;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			mode_reg <= canlp_pkg::MODE_SOFTRST;
			ctrl_reg <= '{link_en: canlp_pkg::LINK_EN_RST, filt_sel: canlp_pkg::FILT_SEL_RST,
				wake_ie: canlp_pkg::WAKE_IE_RST, soft_rst: canlp_pkg::SOFT_RST_RST,
				sleep_rq: canlp_pkg::SLEEP_RQ_RST};
			wake_flag_reg <= 1'b0;
			filt_cnt_reg <= 8'h00;
		end
		else
		begin
			mode_reg <= mode_next;
			ctrl_reg <= ctrl_next;
			wake_flag_reg <= wake_flag_next;
			filt_cnt_reg <= filt_cnt_next;
		end
	end

	// ------------------------------------------------------------
	// bus resynchronisation after wake or stop
	// ------------------------------------------------------------
	// any mode but normal drops sync; a dominant bit restarts the count
	always_comb
	begin
		synced_next = synced_reg;
		resync_cnt_next = resync_cnt_reg;
		if (mode_reg != canlp_pkg::MODE_NORMAL)
		begin
			synced_next = 1'b0;
			resync_cnt_next = 4'h0;
		end
		else if (!synced_reg && core_bit_tick)
		begin
			if (!rx_level_reg)
				resync_cnt_next = 4'h0;
			else if (resync_cnt_reg == RESYNC_LAST)
				synced_next = 1'b1;
			else
				resync_cnt_next = resync_cnt_reg + 4'h1;
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			synced_reg <= 1'b0;
			resync_cnt_reg <= 4'h0;
		end
		else
		begin
			synced_reg <= synced_next;
			resync_cnt_reg <= resync_cnt_next;
		end
	end

	// ------------------------------------------------------------
	// timer link: pulse from one bit edge to the next after a valid frame
	// ------------------------------------------------------------
	always_comb
	begin
		pulse_arm_next = pulse_arm_reg;
		pulse_next = pulse_reg;
		if (core_bit_tick)
		begin
			pulse_next = pulse_arm_reg;
			pulse_arm_next = 1'b0;
		end
		if (core_frame_ok && mode_reg == canlp_pkg::MODE_NORMAL)
			pulse_arm_next = 1'b1;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			pulse_arm_reg <= 1'b0;
			pulse_reg <= 1'b0;
		end
		else
		begin
			pulse_arm_reg <= pulse_arm_next;
			pulse_reg <= pulse_next;
		end
	end

	// ------------------------------------------------------------
	// axi4-lite answers, one cycle after the request is taken
	// ------------------------------------------------------------
	always_comb
	begin
		bvalid_next = bvalid_reg && !s_axi_bready;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg && !s_axi_rready;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		if (wr_go)
		begin
			bvalid_next = 1'b1;
			if (mode_reg == canlp_pkg::MODE_PWRDN)
				bresp_next = canlp_pkg::RESP_SLVERR;
			else if (s_axi_awaddr == canlp_pkg::OFS_CTRL || s_axi_awaddr == canlp_pkg::OFS_FLAG ||
				s_axi_awaddr == canlp_pkg::OFS_STATUS)
				bresp_next = canlp_pkg::RESP_OKAY;
			else
				bresp_next = canlp_pkg::RESP_DECERR;
		end
		if (rd_go)
		begin
			rvalid_next = 1'b1;
			rresp_next = canlp_pkg::RESP_OKAY;
			rdata_next = 32'h0000_0000;
			if (mode_reg == canlp_pkg::MODE_PWRDN)
				rresp_next = canlp_pkg::RESP_SLVERR;
			else if (s_axi_araddr == canlp_pkg::OFS_CTRL)
				rdata_next[4:0] = ctrl_reg;
			else if (s_axi_araddr == canlp_pkg::OFS_STATUS)
			begin
				rdata_next[canlp_pkg::STAT_SLEEP_ACK] = (mode_reg == canlp_pkg::MODE_SLEEP);
				rdata_next[canlp_pkg::STAT_MODE_LSB +: 4] = mode_reg;
				rdata_next[canlp_pkg::STAT_SYNCED] = synced_reg;
			end
			else if (s_axi_araddr == canlp_pkg::OFS_FLAG)
				rdata_next[canlp_pkg::FLAG_WAKE] = wake_flag_reg;
			else
				rresp_next = canlp_pkg::RESP_DECERR;
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			bvalid_reg <= 1'b0;
			bresp_reg <= 2'h0;
			rvalid_reg <= 1'b0;
			rresp_reg <= 2'h0;
			rdata_reg <= 32'h0000_0000;
		end
		else
		begin
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
		end
	end

	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = rd_go;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;

	// ------------------------------------------------------------
	// outputs to core, cpu and pins
	// ------------------------------------------------------------
	assign core_clk_en = (mode_reg == canlp_pkg::MODE_NORMAL);
	assign reg_clk_en = (mode_reg != canlp_pkg::MODE_PWRDN);
	assign core_halt = (mode_reg == canlp_pkg::MODE_SOFTRST) ||
		(mode_reg == canlp_pkg::MODE_PWRDN);
	// copies, aborts and queued sends run only once back on the bus
	assign core_pending_en = core_clk_en && synced_reg;
	assign busoff_count_en = core_bus_off && core_clk_en && core_bit_tick && rx_level_reg;
	// an unsynced core sees an idle line, so the waking frame is lost
	assign core_rx_bit = synced_reg ? rx_level_reg : 1'b1;
	assign can_tx = core_pending_en ? core_tx_bit : 1'b1;
	assign cpu_stop_wake = cpu_stop && !rx_level_reg;
	assign cpu_wait_exit = cpu_wait && core_irq && core_clk_en;
	assign wakeup_irq = wake_flag_reg && ctrl_reg.wake_ie &&
		(mode_reg != canlp_pkg::MODE_PWRDN || cpu_stop);
	assign capture_ch0 = pulse_reg && ctrl_reg.link_en;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_stopped;
		cpu_stop;
	endsequence
	sequence s_idle_req;
		mode_reg == canlp_pkg::MODE_NORMAL && ctrl_reg.sleep_rq && !ctrl_next.soft_rst &&
			!core_tx_pending && !core_rx_busy;
	endsequence

	chk_stop_pwrdn: assert property (s_stopped |=> mode_reg == canlp_pkg::MODE_PWRDN)
		else $error("cpu stop did not enter power-down");
	chk_sleep_entry: assert property ((s_idle_req and !cpu_stop) |=> mode_reg == canlp_pkg::MODE_SLEEP)
		else $error("idle sleep request not honoured");
	chk_busy_defer: assert property (mode_reg == canlp_pkg::MODE_NORMAL && (core_tx_pending ||
		core_rx_busy) |=> mode_reg != canlp_pkg::MODE_SLEEP)
		else $error("sleep entered while busy");
	chk_tx_recessive: assert property (asleep |-> can_tx)
		else $error("transmit not recessive in low power");
	chk_clock_gate: assert property (mode_reg != canlp_pkg::MODE_NORMAL |-> !core_clk_en &&
		!busoff_count_en)
		else $error("core clock running in low power");
	chk_resync_wait: assert property ($rose(mode_reg == canlp_pkg::MODE_NORMAL) |->
		!synced_reg [*8])
		else $error("resync finished too early");
	chk_wake_irq: assert property (wakeup_irq |-> ctrl_reg.wake_ie && wake_flag_reg)
		else $error("wakeup irq without enable");
	chk_flag_hold: assert property (activity && ctrl_reg.wake_ie |=> wake_flag_reg)
		else $error("wakeup flag lost");
	// the pulse stands a whole bit time, so only its edges line up with a tick
	chk_link_gate: assert property (capture_ch0 |-> ctrl_reg.link_en && pulse_reg)
		else $error("capture pulse ungated");
	chk_pulse_edge: assert property ($changed(pulse_reg) |-> $past(core_bit_tick))
		else $error("frame pulse edge off the bit tick");
	chk_halt_soft: assert property (ctrl_next.soft_rst && !cpu_stop |=> core_halt)
		else $error("soft reset did not halt core");
	chk_rq_keep: assert property (mode_reg == canlp_pkg::MODE_NORMAL && ctrl_reg.sleep_rq &&
		!cpu_stop |=> ctrl_reg.sleep_rq)
		else $error("request cleared before acknowledge");
endmodule // canlp_top
`default_nettype wire

// File: dv/canlp_bus_model.sv
/*
  canlp_bus_model: can bus line and bit-time tick seen by the controller.
  assumes: bench drives dom_req right after rising edges; bus idles recessive.
*/
`timescale 1ns/10ps
`default_nettype none
module canlp_bus_model #(
	parameter int TICK = 8 // clocks per bit time
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// bench control
	input wire logic dom_req,
	// bus side
	output logic can_rx,
	output logic core_bit_tick
);
	logic [7:0] cnt_reg; // position inside the bit time
	// bus resistors pull the line recessive whenever no node drives it
	assign can_rx = dom_req ? 1'b0 : 1'b1;
	// free-running prescaler, like the core's own
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			cnt_reg <= 8'h00;
		else
			cnt_reg <= (cnt_reg == 8'(TICK - 1)) ? 8'h00 : cnt_reg + 8'h01;
	end
	assign core_bit_tick = (cnt_reg == 8'(TICK - 1));
endmodule // canlp_bus_model
`default_nettype wire

// File: dv/canlp_top_tb_top.sv
/*
  canlp_top_tb_top: self-checking bench for the low-power controller.
  assumes: canlp_pkg compiled first; bus model supplies rx line and bit tick.
*/
`timescale 1ns/10ps
`default_nettype none
module canlp_top_tb_top;
	localparam int TICK = 8; // clocks per bit time
	localparam int LIMIT = 20000; // cycle ceiling, run needs a few hundred
	// design inputs
	logic clock = 1'b0, rst = 1'b1, bus_dom = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cpu_stop = 1'b0, cpu_wait = 1'b0;
	logic core_tx_pending = 1'b0, core_rx_busy = 1'b0, core_bus_off = 1'b0;
	logic core_frame_ok = 1'b0, core_irq = 1'b0, core_tx_bit = 1'b1;
	// design outputs
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, rd_q;
	logic cpu_stop_wake, cpu_wait_exit, core_rx_bit, core_clk_en, reg_clk_en, core_halt;
	logic core_pending_en, busoff_count_en, can_rx, can_tx, wakeup_irq, capture_ch0;
	logic core_bit_tick;
	int errors = 0, check_count = 0, cyc = 0;

	canlp_top u_canlp_top (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_stop, .cpu_wait,
		.cpu_stop_wake, .cpu_wait_exit, .core_tx_pending, .core_rx_busy, .core_bus_off,
		.core_bit_tick, .core_frame_ok, .core_irq, .core_tx_bit, .core_rx_bit,
		.core_clk_en, .reg_clk_en, .core_halt, .core_pending_en, .busoff_count_en,
		.can_rx, .can_tx, .wakeup_irq, .capture_ch0);
	canlp_bus_model #(.TICK(TICK)) u_canlp_bus_model (.clock, .rst, .dom_req(bus_dom),
		.can_rx, .core_bit_tick);

	// clock and hang guard
	always #2 clock = ~clock;
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			errors++;
			final_report();
		end
	end

	task automatic final_report;
		begin
			$display("checks %0d errors %0d", check_count, errors);
			if (errors == 0 && check_count > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask

	task automatic ck(input logic [31:0] g, input logic [31:0] e);
		begin
			check_count++;
			if (g !== e)
			begin
				errors++;
				$display("mismatch at %0t: got %h expected %h", $time, g, e);
			end
		end
	endtask

	// expected status word: ack, one-hot mode, synced
	function automatic logic [31:0] st(logic a, canlp_pkg::canlp_mode_e m, logic s);
		return {26'h0, s, m, a};
	endfunction

	// bus cycles: answers are looked at on the falling edge, taken on the next rising one
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		begin
			@(posedge clock);
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			@(negedge clock);
			while (s_axi_awready !== 1'b1) @(negedge clock);
			@(posedge clock);
			s_axi_awvalid <= 1'b0;
			s_axi_wvalid <= 1'b0;
			@(negedge clock);
			while (s_axi_bvalid !== 1'b1) @(negedge clock);
			ck({30'h0, s_axi_bresp}, {30'h0, er});
			@(posedge clock);
			s_axi_bready <= 1'b0;
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		begin
			@(posedge clock);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			@(negedge clock);
			while (s_axi_arready !== 1'b1) @(negedge clock);
			@(posedge clock);
			s_axi_arvalid <= 1'b0;
			@(negedge clock);
			while (s_axi_rvalid !== 1'b1) @(negedge clock);
			rd_q = s_axi_rdata;
			if (e !== 32'hFFFFFFFF)
				ck({s_axi_rresp, rd_q[29:0]}, {er, e[29:0]});
			@(posedge clock);
			s_axi_rready <= 1'b0;
		end
	endtask

	// count cycles of capture pulse within three bit times after a frame
	task automatic frame_pulse(output int n);
		begin
			n = 0;
			@(posedge clock);
			core_frame_ok <= 1'b1;
			@(posedge clock);
			core_frame_ok <= 1'b0;
			repeat (3 * TICK)
			begin
				@(negedge clock);
				n += int'(capture_ch0 === 1'b1);
			end
		end
	endtask

	task automatic t_reset;
		begin
			rd(canlp_pkg::OFS_CTRL, 32'h02, canlp_pkg::RESP_OKAY);
			rd(canlp_pkg::OFS_STATUS, st(0, canlp_pkg::MODE_SOFTRST, 0), 2'h0);
			rd(8'h0C, 32'h0, canlp_pkg::RESP_DECERR);
			ck({core_halt, core_clk_en, reg_clk_en}, 32'h5);
		end
	endtask

	task automatic t_normal;
		int n;
		begin
			core_tx_bit <= 1'b0;
			wr(canlp_pkg::OFS_CTRL, 32'h0, 2'h0);
			rd(canlp_pkg::OFS_STATUS, st(0, canlp_pkg::MODE_NORMAL, 0), 2'h0);
			ck(can_tx, 32'h1);
			rd_q = 32'h0;
			while (rd_q[canlp_pkg::STAT_SYNCED] !== 1'b1)
				rd(canlp_pkg::OFS_STATUS, 32'hFFFFFFFF, 2'h0);
			ck({can_tx, core_pending_en}, 32'h1);
			core_tx_bit <= 1'b1;
			cpu_wait <= 1'b1;
			core_irq <= 1'b1;
			@(negedge clock);
			ck(cpu_wait_exit, 32'h1);
			@(posedge clock);
			cpu_wait <= 1'b0;
			core_irq <= 1'b0;
			wr(canlp_pkg::OFS_CTRL, 32'h10, 2'h0);
			frame_pulse(n);
			ck(n, TICK);
			wr(canlp_pkg::OFS_CTRL, 32'h0, 2'h0);
			frame_pulse(n);
			ck(n, 0);
		end
	endtask

	task automatic t_sleep;
		int n;
		begin
			@(posedge clock);
			core_tx_pending <= 1'b1;
			wr(canlp_pkg::OFS_CTRL, 32'h01, 2'h0);
			wr(canlp_pkg::OFS_CTRL, 32'h00, 2'h0);
			rd(canlp_pkg::OFS_CTRL, 32'h01, 2'h0);
			core_tx_pending <= 1'b0;
			core_rx_busy <= 1'b1;
			rd(canlp_pkg::OFS_STATUS, st(0, canlp_pkg::MODE_NORMAL, 1), 2'h0);
			core_rx_busy <= 1'b0;
			core_tx_bit <= 1'b0;
			core_bus_off <= 1'b1;
			rd(canlp_pkg::OFS_STATUS, st(1, canlp_pkg::MODE_SLEEP, 1), 2'h0);
			n = 0;
			repeat (3 * TICK)
			begin
				@(negedge clock);
				n += int'(busoff_count_en !== 1'b0);
			end
			ck(n, 0);
			ck({can_tx, core_clk_en, reg_clk_en, core_pending_en}, 32'hA);
			wr(canlp_pkg::OFS_CTRL, 32'h00, 2'h0);
			rd(canlp_pkg::OFS_STATUS, st(0, canlp_pkg::MODE_NORMAL, 0), 2'h0);
			// awake and still bus-off: one recovery count per recessive bit time
			n = 0;
			repeat (3 * TICK)
			begin
				@(negedge clock);
				n += int'(busoff_count_en === 1'b1);
			end
			ck(n, 3);
			@(posedge clock);
			core_bus_off <= 1'b0;
			core_tx_bit <= 1'b1;
		end
	endtask

	task automatic t_wake;
		begin
			wr(canlp_pkg::OFS_CTRL, 32'h0D, 2'h0);
			bus_dom <= 1'b1;
			repeat (8) @(posedge clock);
			bus_dom <= 1'b0;
			rd(canlp_pkg::OFS_STATUS, st(1, canlp_pkg::MODE_SLEEP, 0), 2'h0);
			bus_dom <= 1'b1;
			repeat (30) @(posedge clock);
			bus_dom <= 1'b0;
			rd(canlp_pkg::OFS_STATUS, st(0, canlp_pkg::MODE_NORMAL, 0), 2'h0);
			rd(canlp_pkg::OFS_FLAG, 32'h1, 2'h0);
			wr(canlp_pkg::OFS_FLAG, 32'h1, 2'h0);
			rd(canlp_pkg::OFS_FLAG, 32'h0, 2'h0);
			ck(wakeup_irq, 32'h0);
		end
	endtask

	task automatic t_soft_stop;
		begin
			wr(canlp_pkg::OFS_CTRL, 32'h01, 2'h0);
			wr(canlp_pkg::OFS_CTRL, 32'h03, 2'h0);
			rd(canlp_pkg::OFS_STATUS, st(0, canlp_pkg::MODE_SOFTRST, 0), 2'h0);
			wr(canlp_pkg::OFS_CTRL, 32'h01, 2'h0);
			cpu_stop <= 1'b1;
			repeat (2) @(posedge clock);
			ck({can_tx, reg_clk_en, cpu_stop_wake}, 32'h4);
			rd(canlp_pkg::OFS_STATUS, 32'h0, canlp_pkg::RESP_SLVERR);
			wr(canlp_pkg::OFS_CTRL, 32'h0, canlp_pkg::RESP_SLVERR);
			bus_dom <= 1'b1;
			repeat (8) @(posedge clock);
			ck({cpu_stop_wake, core_rx_bit}, 32'h3);
			bus_dom <= 1'b0;
			cpu_stop <= 1'b0;
			rd(canlp_pkg::OFS_CTRL, 32'h01, 2'h0);
		end
	endtask

	// main sequence
	initial
	begin
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		t_reset();
		t_normal();
		t_sleep();
		t_wake();
		t_soft_stop();
		final_report();
	end
endmodule // canlp_top_tb_top
`default_nettype wire
